/* File: rtl/crm_pkg.sv */
package crm_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CONFIG = 12'hfde;
    localparam logic [11:0] IDX_STATUS = 12'hfdf;
    localparam logic [11:0] IDX_COMMIT = 12'hfe0;
    localparam int ADDR_W = 14;

    // map_config_staged / map_status_committed fields
    localparam int BIT_RST_DIS = 0;
    localparam int BIT_RAM_MAP = 1;
    localparam int BIT_VEC_REL = 2;
    localparam logic [2:0] CONFIG_RESET = 3'h0;

    // commit key codes
    localparam logic [7:0] KEY_ALL = 8'hd4;
    localparam logic [7:0] KEY_RST_DIS = 8'hb2;
    localparam logic [7:0] KEY_FLAG_CLR = 8'h71;

    // code and data space landmarks
    localparam logic [15:0] RAM_FIRST = 16'h0040;
    localparam logic [15:0] RAM_LAST = 16'h083f;
    localparam logic [15:0] BOOT_FIRST = 16'h1000;
    localparam logic [15:0] BOOT_LAST = 16'h17ff;
    localparam logic [15:0] FLASH_FIRST = 16'h8000;
    localparam logic [15:0] CALL_VEC_FIRST = 16'hffa0;
    localparam logic [15:0] CALL_VEC_LAST = 16'hffbf;
    localparam logic [15:0] INT_VEC_FIRST = 16'hffcc;
    localparam logic [15:0] INT_VEC_LAST = 16'hfffd;
    localparam logic [15:0] VEC_SHIFT = 16'hfe00;
    localparam logic [15:0] SFR1_LAST = 16'h003f;
    localparam logic [15:0] SFR3_FIRST = 16'h0e40;
    localparam logic [15:0] SFR2_LAST = 16'h0fff;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_SFR,
        TGT_RAM,
        TGT_SWI,
        TGT_BOOT,
        TGT_FLASH
    } crm_target_t;

    function automatic logic isMapped(input logic [11:0] idx);
        return idx == IDX_CONFIG || idx == IDX_STATUS || idx == IDX_COMMIT;
    endfunction

    function automatic logic inRange(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        return a >= lo && a <= hi;
    endfunction
endpackage

/* File: rtl/crm_regbus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface crm_regbus_if;
    logic wrEn;
    logic [11:0] wrIdx;
    logic [7:0] wrData;
    logic wrLane;
    logic [11:0] rdIdx;
    logic [7:0] rdData;

    modport slave (output wrEn, wrIdx, wrData, wrLane, rdIdx, input rdData);
    modport regs (input wrEn, wrIdx, wrData, wrLane, rdIdx, output rdData);
endinterface
`default_nettype wire

/* File: rtl/crm_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module crm_axil_slave (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite
    input wire logic [crm_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [crm_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    crm_regbus_if.slave bus
);
    logic awFull;
    logic wFull;
    logic arFull;

    // write channels, taken in either order
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awFull <= 1'b0;
            wFull <= 1'b0;
            bvalid <= 1'b0;
            bresp <= crm_pkg::RESP_OKAY;
            bus.wrEn <= 1'b0;
            bus.wrIdx <= 12'h000;
            bus.wrData <= 8'h00;
            bus.wrLane <= 1'b0;
        end else begin
            bus.wrEn <= 1'b0;
            if (awvalid && awready) begin
                bus.wrIdx <= awaddr[crm_pkg::ADDR_W-1:2];
                awFull <= 1'b1;
                awready <= 1'b0;
            end else if (!awFull && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                bus.wrData <= wdata[7:0];
                bus.wrLane <= wstrb[0];
                wFull <= 1'b1;
                wready <= 1'b0;
            end else if (!wFull && !bvalid) begin
                wready <= 1'b1;
            end
            if (awFull && wFull && !bvalid) begin
                bus.wrEn <= crm_pkg::isMapped(bus.wrIdx);
                bresp <= crm_pkg::isMapped(bus.wrIdx) ?
                         crm_pkg::RESP_OKAY : crm_pkg::RESP_SLVERR;
                bvalid <= 1'b1;
                awFull <= 1'b0;
                wFull <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            arready <= 1'b0;
            arFull <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= crm_pkg::RESP_OKAY;
            bus.rdIdx <= 12'h000;
        end else begin
            if (arvalid && arready) begin
                bus.rdIdx <= araddr[crm_pkg::ADDR_W-1:2];
                arFull <= 1'b1;
                arready <= 1'b0;
            end else if (!arFull && !rvalid) begin
                arready <= 1'b1;
            end
            if (arFull && !rvalid) begin
                rdata <= {24'h000000, bus.rdData};
                rresp <= crm_pkg::isMapped(bus.rdIdx) ?
                         crm_pkg::RESP_OKAY : crm_pkg::RESP_SLVERR;
                rvalid <= 1'b1;
                arFull <= 1'b0;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/crm_code_area_ram_remap.sv */
// Overview of operation
// - code and data spaces, 64 Kbytes each, decoded independently.
// - after reset RAM is in data space only, not in code space.
// - committed RAM select maps code 0x0040-0x083F onto RAM.
// - relocate moves call and interrupt vectors to 0x01xx; reset stays.
// - serial programming mode always maps RAM into code space.
// - unmapped code RAM window fetches return the software interrupt opcode.
// - staged RAM select has no effect until key 0xD4 is written.
// - key 0xD4 commits all staged settings; 0xB2 only reset disable, 0x71 only flag clear; others do nothing.
// - config bits 7..3 read zero; bit2 relocate, bit1 RAM, bit0 reset.
// - status bits 1 and 2 show committed RAM and relocate values.
// - status bits 7..3 always read zero.
// - outside serial mode only the first 2 Kbytes of boot ROM map.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module crm_code_area_ram_remap #(
    parameter logic [7:0] SWI_OPCODE = 8'hff,
    parameter logic [15:0] BOOT_SERIAL_LAST = 16'h1fff
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite register bus
    input wire logic [crm_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [crm_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // mode and neighbour controls
    input wire logic serialProgMode,
    input wire logic bootRomEnable,
    input wire logic flagClearStaged,
    // instruction fetch path
    input wire logic fetchReq,
    input wire logic [15:0] fetchAddr,
    output logic fetchAck,
    output crm_pkg::crm_target_t fetchTarget,
    output logic [15:0] fetchMemAddr,
    output logic [7:0] fetchForceData,
    // data access path
    input wire logic dataReq,
    input wire logic [15:0] dataAddr,
    output logic dataAck,
    output crm_pkg::crm_target_t dataTarget,
    output logic [15:0] dataMemAddr,
    // committed settings
    output logic codeRamSelectState,
    output logic vectorRelocateState,
    output logic resetDisable,
    output logic flagClearPulse
);
    crm_regbus_if bus ();

    logic stagedRst;
    logic stagedRam;
    logic stagedVec;
    logic keyWrite;
    logic [15:0] next_fetchAddr;
    crm_pkg::crm_target_t next_fetchTarget;
    crm_pkg::crm_target_t next_dataTarget;

    crm_axil_slave u_slave (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus)
    );

    // boot rom window; only 2 Kbytes outside serial mode
    function automatic logic inBoot(input logic [15:0] a,
                                    input logic serial);
        return crm_pkg::inRange(a, crm_pkg::BOOT_FIRST,
            serial ? BOOT_SERIAL_LAST : crm_pkg::BOOT_LAST);
    endfunction

    // staged configuration
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stagedRst <= crm_pkg::CONFIG_RESET[crm_pkg::BIT_RST_DIS];
            stagedRam <= crm_pkg::CONFIG_RESET[crm_pkg::BIT_RAM_MAP];
            stagedVec <= crm_pkg::CONFIG_RESET[crm_pkg::BIT_VEC_REL];
        end else if (bus.wrEn && bus.wrLane &&
                     bus.wrIdx == crm_pkg::IDX_CONFIG) begin
            stagedRst <= bus.wrData[crm_pkg::BIT_RST_DIS];
            stagedRam <= bus.wrData[crm_pkg::BIT_RAM_MAP];
            stagedVec <= bus.wrData[crm_pkg::BIT_VEC_REL];
        end
    end

    assign keyWrite = bus.wrEn && bus.wrLane &&
                      bus.wrIdx == crm_pkg::IDX_COMMIT;

    // commit key; write-only, no stored value
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            codeRamSelectState <= 1'b0;
            vectorRelocateState <= 1'b0;
            resetDisable <= 1'b0;
            flagClearPulse <= 1'b0;
        end else begin
            flagClearPulse <= 1'b0;
            if (keyWrite) begin
                case (bus.wrData)
                    crm_pkg::KEY_ALL: begin
                        codeRamSelectState <= stagedRam;
                        vectorRelocateState <= stagedVec;
                        resetDisable <= stagedRst;
                        flagClearPulse <= flagClearStaged;
                    end
                    crm_pkg::KEY_RST_DIS: begin
                        resetDisable <= stagedRst;
                    end
                    crm_pkg::KEY_FLAG_CLR: begin
                        flagClearPulse <= flagClearStaged;
                    end
                    default: begin
                        flagClearPulse <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register read data
    always_comb begin
        bus.rdData = 8'h00;
        case (bus.rdIdx)
            crm_pkg::IDX_CONFIG: begin
                bus.rdData = {5'h00, stagedVec, stagedRam, stagedRst};
            end
            crm_pkg::IDX_STATUS: begin
                bus.rdData = {5'h00, vectorRelocateState,
                              codeRamSelectState, resetDisable};
            end
            default: begin
                bus.rdData = 8'h00;
            end
        endcase
    end

    // code space decode with vector relocation
    always_comb begin
        next_fetchAddr = fetchAddr;
        if (vectorRelocateState &&
            (crm_pkg::inRange(fetchAddr, crm_pkg::CALL_VEC_FIRST,
                              crm_pkg::CALL_VEC_LAST) ||
             crm_pkg::inRange(fetchAddr, crm_pkg::INT_VEC_FIRST,
                              crm_pkg::INT_VEC_LAST))) begin
            next_fetchAddr = fetchAddr - crm_pkg::VEC_SHIFT;
        end
        next_fetchTarget = crm_pkg::TGT_NONE;
        if (crm_pkg::inRange(next_fetchAddr, crm_pkg::RAM_FIRST,
                             crm_pkg::RAM_LAST)) begin
            next_fetchTarget = (codeRamSelectState || serialProgMode) ?
                crm_pkg::TGT_RAM : crm_pkg::TGT_SWI;
        end else if (bootRomEnable &&
                     inBoot(next_fetchAddr, serialProgMode)) begin
            next_fetchTarget = crm_pkg::TGT_BOOT;
        end else if (next_fetchAddr >= crm_pkg::FLASH_FIRST) begin
            next_fetchTarget = crm_pkg::TGT_FLASH;
        end
    end

    // data space decode, independent of code space
    always_comb begin
        next_dataTarget = crm_pkg::TGT_NONE;
        if (dataAddr <= crm_pkg::SFR1_LAST ||
            crm_pkg::inRange(dataAddr, crm_pkg::SFR3_FIRST,
                             crm_pkg::SFR2_LAST)) begin
            next_dataTarget = crm_pkg::TGT_SFR;
        end else if (crm_pkg::inRange(dataAddr, crm_pkg::RAM_FIRST,
                                      crm_pkg::RAM_LAST)) begin
            next_dataTarget = crm_pkg::TGT_RAM;
        end else if (bootRomEnable && inBoot(dataAddr, serialProgMode)) begin
            next_dataTarget = crm_pkg::TGT_BOOT;
        end else if (dataAddr >= crm_pkg::FLASH_FIRST) begin
            next_dataTarget = crm_pkg::TGT_FLASH;
        end
    end

    // fetch answer register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fetchAck <= 1'b0;
            fetchTarget <= crm_pkg::TGT_NONE;
            fetchMemAddr <= 16'h0000;
            fetchForceData <= 8'h00;
        end else begin
            fetchAck <= fetchReq;
            if (fetchReq) begin
                fetchTarget <= next_fetchTarget;
                fetchMemAddr <= next_fetchAddr;
                fetchForceData <= (next_fetchTarget == crm_pkg::TGT_SWI) ?
                                  SWI_OPCODE : 8'h00;
            end
        end
    end

    // data answer register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dataAck <= 1'b0;
            dataTarget <= crm_pkg::TGT_NONE;
            dataMemAddr <= 16'h0000;
        end else begin
            dataAck <= dataReq;
            if (dataReq) begin
                dataTarget <= next_dataTarget;
                dataMemAddr <= dataAddr;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/crm_remap_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module crm_remap_assertions #(
    parameter logic [7:0] SWI_OPCODE = 8'hff
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register bus
    input wire logic bvalid,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic serialProgMode,
    // code and data paths
    input wire logic fetchReq,
    input wire logic [15:0] fetchAddr,
    input wire logic fetchAck,
    input wire crm_pkg::crm_target_t fetchTarget,
    input wire logic [15:0] fetchMemAddr,
    input wire logic [7:0] fetchForceData,
    input wire logic dataReq,
    input wire logic [15:0] dataAddr,
    input wire logic dataAck,
    input wire crm_pkg::crm_target_t dataTarget,
    // committed settings
    input wire logic codeRamSelectState,
    input wire logic vectorRelocateState,
    input wire logic flagClearPulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire fWin = fetchAddr >= 16'h0040 && fetchAddr <= 16'h083f;
    wire dWin = dataAddr >= 16'h0040 && dataAddr <= 16'h083f;
    wire vec = (fetchAddr >= 16'hffa0 && fetchAddr <= 16'hffbf) ||
        (fetchAddr >= 16'hffcc && fetchAddr <= 16'hfffd);
    wire ramOn = codeRamSelectState || serialProgMode;
    sequence winFetch;
        fetchReq && fWin;
    endsequence
    fetch_ack_a: assert property (fetchAck == $past(fetchReq))
        else $error("fetch ack not one cycle after request");
    data_ack_a: assert property (dataReq |=> dataAck)
        else $error("data ack missing");
    code_swi_a: assert property (winFetch ##0 !ramOn |=>
        fetchTarget == crm_pkg::TGT_SWI && fetchForceData == SWI_OPCODE)
        else $error("unmapped window fetch not software interrupt");
    code_ram_a: assert property (winFetch ##0 ramOn |=>
        fetchTarget == crm_pkg::TGT_RAM && fetchForceData == 8'h00)
        else $error("mapped window fetch not served from ram");
    data_ram_a: assert property (dataReq && dWin |=>
        dataTarget == crm_pkg::TGT_RAM)
        else $error("data window not ram");
    vector_move_a: assert property (fetchReq && vectorRelocateState && vec
        |=> fetchMemAddr == $past(fetchAddr) - 16'hfe00)
        else $error("vector not relocated");
    reset_vector_a: assert property (fetchReq && fetchAddr >= 16'hfffe
        |=> fetchMemAddr == $past(fetchAddr))
        else $error("reset vector moved");
    commit_only_a: assert property ($changed(codeRamSelectState) ||
        $changed(vectorRelocateState) |-> $past(bvalid))
        else $error("map changed without a write");
    read_zero_a: assert property (rvalid |-> rdata[31:3] == 29'h0)
        else $error("unused read bits not zero");
    clear_pulse_a: assert property (flagClearPulse |->
        $past(bvalid) ##1 !flagClearPulse)
        else $error("flag clear pulse malformed");
endmodule
bind crm_code_area_ram_remap crm_remap_assertions #(
    .SWI_OPCODE(SWI_OPCODE)
) chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bvalid(bvalid),
    .rvalid(rvalid), .rdata(rdata), .serialProgMode(serialProgMode),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck),
    .fetchTarget(fetchTarget), .fetchMemAddr(fetchMemAddr),
    .fetchForceData(fetchForceData), .dataReq(dataReq),
    .dataAddr(dataAddr), .dataAck(dataAck), .dataTarget(dataTarget),
    .codeRamSelectState(codeRamSelectState),
    .vectorRelocateState(vectorRelocateState),
    .flagClearPulse(flagClearPulse)
);
`default_nettype wire

/* File: bench/crm_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module crm_cpu_model (
    // clock
    input wire logic clk_sys,
    // fetch and data requests
    output logic fetchReq,
    output logic [15:0] fetchAddr,
    output logic dataReq,
    output logic [15:0] dataAddr
);
    initial begin
        fetchReq = 1'b0;
        fetchAddr = 16'h0;
        dataReq = 1'b0;
        dataAddr = 16'h0;
    end
    // same address in both spaces at once
    task automatic access(input logic [15:0] a);
        fetchReq <= 1'b1;
        fetchAddr <= a;
        dataReq <= 1'b1;
        dataAddr <= a;
        @(posedge clk_sys);
        fetchReq <= 1'b0;
        dataReq <= 1'b0;
        fetchAddr <= ~a;
        dataAddr <= ~a;
        // return mid-cycle while the one-cycle answer stands
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: bench/crm_code_area_ram_remap_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, s, e) begin \
    samplesChecked++; \
    if ((s) !== (e)) begin \
        miscompares++; \
        $display("unexpected %s exp %h got %h", nm, e, s); \
    end \
end
module crm_code_area_ram_remap_tb_top;
    localparam logic [7:0] SWI_OP = 8'h5a;
    localparam logic [1:0] OK = crm_pkg::RESP_OKAY;
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic [13:0] awaddr = 14'h0, araddr = 14'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic serialProgMode = 1'b0, bootRomEnable = 1'b0;
    logic flagClearStaged = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic fetchReq, fetchAck, dataReq, dataAck;
    logic [15:0] fetchAddr, fetchMemAddr, dataAddr, dataMemAddr;
    logic [7:0] fetchForceData;
    crm_pkg::crm_target_t fetchTarget, dataTarget;
    logic codeRamSelectState, vectorRelocateState;
    logic resetDisable, flagClearPulse;
    int miscompares = 0, samplesChecked = 0, cycles = 0, pulses = 0;

    crm_code_area_ram_remap #(.SWI_OPCODE(SWI_OP)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serialProgMode(serialProgMode), .bootRomEnable(bootRomEnable),
        .flagClearStaged(flagClearStaged), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .fetchAck(fetchAck),
        .fetchTarget(fetchTarget), .fetchMemAddr(fetchMemAddr),
        .fetchForceData(fetchForceData), .dataReq(dataReq),
        .dataAddr(dataAddr), .dataAck(dataAck), .dataTarget(dataTarget),
        .dataMemAddr(dataMemAddr), .codeRamSelectState(codeRamSelectState),
        .vectorRelocateState(vectorRelocateState),
        .resetDisable(resetDisable), .flagClearPulse(flagClearPulse)
    );
    crm_cpu_model cpu (
        .clk_sys(clk_sys), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
        .dataReq(dataReq), .dataAddr(dataAddr)
    );

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (flagClearPulse === 1'b1) pulses <= pulses + 1;
        if (cycles == 5000) begin
            miscompares++;
            testDone();
        end
    end

    task automatic testDone();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] i, input logic [7:0] d,
            input logic [1:0] r);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        `CHK("bresp", bresp, r)
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] i, input logic [7:0] d,
            input logic [1:0] r);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        `CHK("rdata", rdata, {24'h0, d})
        `CHK("rresp", rresp, r)
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic probe(input logic [15:0] a,
            input crm_pkg::crm_target_t ft, input logic [15:0] fm,
            input crm_pkg::crm_target_t dt);
        logic [7:0] ef;
        ef = (ft == crm_pkg::TGT_SWI) ? SWI_OP : 8'h00;
        cpu.access(a);
        `CHK("fetchAck", fetchAck, 1'b1)
        `CHK("fetchTarget", fetchTarget, ft)
        `CHK("fetchMemAddr", fetchMemAddr, fm)
        `CHK("fetchForceData", fetchForceData, ef)
        `CHK("dataTarget", dataTarget, dt)
        `CHK("dataMemAddr", dataMemAddr, a)
        `CHK("dataAck", dataAck, 1'b1)
        @(posedge clk_sys);
    endtask

    task automatic afterReset();
        rd(crm_pkg::IDX_CONFIG, 8'h00, OK);
        rd(crm_pkg::IDX_STATUS, 8'h00, OK);
        probe(16'h0040, crm_pkg::TGT_SWI, 16'h0040, crm_pkg::TGT_RAM);
        probe(16'h003f, crm_pkg::TGT_NONE, 16'h003f, crm_pkg::TGT_SFR);
    endtask

    task automatic staging();
        wr(crm_pkg::IDX_CONFIG, 8'hff, OK);
        rd(crm_pkg::IDX_CONFIG, 8'h07, OK);
        rd(crm_pkg::IDX_STATUS, 8'h00, OK);
        probe(16'h083f, crm_pkg::TGT_SWI, 16'h083f, crm_pkg::TGT_RAM);
        wr(crm_pkg::IDX_COMMIT, 8'h55, OK);
        rd(crm_pkg::IDX_STATUS, 8'h00, OK);
        rd(crm_pkg::IDX_COMMIT, 8'h00, OK);
    endtask

    task automatic commitAll();
        flagClearStaged <= 1'b1;
        wr(crm_pkg::IDX_COMMIT, 8'hd4, OK);
        rd(crm_pkg::IDX_STATUS, 8'h07, OK);
        `CHK("pulses", pulses, 1)
        probe(16'h0040, crm_pkg::TGT_RAM, 16'h0040, crm_pkg::TGT_RAM);
        probe(16'h083f, crm_pkg::TGT_RAM, 16'h083f, crm_pkg::TGT_RAM);
        probe(16'h0840, crm_pkg::TGT_NONE, 16'h0840, crm_pkg::TGT_NONE);
        probe(16'hffa0, crm_pkg::TGT_RAM, 16'h01a0, crm_pkg::TGT_FLASH);
        probe(16'hfffd, crm_pkg::TGT_RAM, 16'h01fd, crm_pkg::TGT_FLASH);
        probe(16'hfffe, crm_pkg::TGT_FLASH, 16'hfffe, crm_pkg::TGT_FLASH);
        probe(16'hffcb, crm_pkg::TGT_FLASH, 16'hffcb, crm_pkg::TGT_FLASH);
    endtask

    task automatic otherKeys();
        wr(crm_pkg::IDX_CONFIG, 8'h00, OK);
        wr(crm_pkg::IDX_COMMIT, 8'hb2, OK);
        `CHK("resetDisable", resetDisable, 1'b0)
        `CHK("codeRamSelect", codeRamSelectState, 1'b1)
        wr(crm_pkg::IDX_COMMIT, 8'h71, OK);
        flagClearStaged <= 1'b0;
        rd(crm_pkg::IDX_STATUS, 8'h06, OK);
        wr(crm_pkg::IDX_COMMIT, 8'hd4, OK);
        rd(crm_pkg::IDX_STATUS, 8'h00, OK);
        `CHK("pulses", pulses, 2)
        probe(16'hffa0, crm_pkg::TGT_FLASH, 16'hffa0, crm_pkg::TGT_FLASH);
        probe(16'h0040, crm_pkg::TGT_SWI, 16'h0040, crm_pkg::TGT_RAM);
    endtask

    task automatic midReset();
        wr(crm_pkg::IDX_CONFIG, 8'h07, OK);
        wr(crm_pkg::IDX_COMMIT, 8'hd4, OK);
        rd(crm_pkg::IDX_STATUS, 8'h07, OK);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(crm_pkg::IDX_CONFIG, 8'h00, OK);
        rd(crm_pkg::IDX_STATUS, 8'h00, OK);
        probe(16'h0040, crm_pkg::TGT_SWI, 16'h0040,
            crm_pkg::TGT_RAM);
    endtask

    task automatic modes();
        serialProgMode <= 1'b1;
        bootRomEnable <= 1'b1;
        probe(16'h0040, crm_pkg::TGT_RAM, 16'h0040, crm_pkg::TGT_RAM);
        probe(16'h1800, crm_pkg::TGT_BOOT, 16'h1800, crm_pkg::TGT_BOOT);
        serialProgMode <= 1'b0;
        probe(16'h17ff, crm_pkg::TGT_BOOT, 16'h17ff, crm_pkg::TGT_BOOT);
        probe(16'h1800, crm_pkg::TGT_NONE, 16'h1800, crm_pkg::TGT_NONE);
        wr(12'h100, 8'h07, crm_pkg::RESP_SLVERR);
        rd(12'h100, 8'h00, crm_pkg::RESP_SLVERR);
        wstrb <= 4'h0;
        wr(crm_pkg::IDX_CONFIG, 8'h07, OK);
        wstrb <= 4'h1;
        rd(crm_pkg::IDX_CONFIG, 8'h00, OK);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        afterReset();
        staging();
        commitAll();
        otherKeys();
        midReset();
        modes();
        testDone();
    end
endmodule
`default_nettype wire
